// ===== inc/i2sw_pkg.sv
package i2sw_pkg;
    // ------------------------------------------------------------
    // Addressing and data
    // ------------------------------------------------------------
    localparam int            I2SW_BYTE_BITS  = 8;
    localparam int            I2SW_CHAN_NUM   = 4;
    localparam int            I2SW_PREFIX_W   = 4;
    localparam int            I2SW_SEL_W      = 3;
    // Fixed address prefix; value arbitrary
    localparam logic [3:0]    I2SW_PREFIX     = 4'h7;
    localparam logic [7:0]    I2SW_CTRL_RST   = 8'h00;
    localparam logic [2:0]    I2SW_BIT_LAST   = 3'h7;
    localparam logic [3:0]    I2SW_CNT_ZERO   = 4'h0;
    localparam logic          I2SW_DIR_READ   = 1'b1;
    // ------------------------------------------------------------
    // Controller timing: serial clock quarter period in core cycles
    // ------------------------------------------------------------
    localparam int            I2SW_HALF_NS    = 24;
    localparam int            I2SW_CLK_NS     = 4;
    localparam int            I2SW_HALF_CYC   = I2SW_HALF_NS / I2SW_CLK_NS;
    localparam logic [7:0]    I2SW_HALF_LAST  = 8'(I2SW_HALF_CYC - 1);
endpackage : i2sw_pkg

// ===== inc/i2sw_if.sv
`timescale 1ns/10ps
// Open-drain two-wire link: a line is low while any end drives it
interface i2sw_if;
    logic scl_oe;
    logic sda_m_oe;
    logic sda_s_oe;
    logic scl;
    logic sda;
    assign scl = ~scl_oe;
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport target (input scl, input sda, output sda_s_oe);
    modport ctrl   (input scl, input sda, output scl_oe, output sda_m_oe);
endinterface : i2sw_if

// ===== logic/i2sw_target.sv
// The placing of the registers and the ctrl_o register output are this design's own decisions.
`timescale 1ns/10ps
// Function
// RL1: Reset pin clears registers, idles, deselects
// RL2: Power-on reset gives all-zero default
// RL3: Sample data once per clock pulse
// RL4: Data change during clock high is framing
// RL5: Controller starts only on idle bus
// RL6: Falling data, clock high: START, readdress
// RL7: Rising data, clock high: STOP, end
// RL8: Eight bits then acknowledge, unlimited bytes
// RL9: Transmitter releases line; extra ack clock
// RL10: Acknowledge address and every written byte
// RL11: Acknowledger holds data low during clock-high
// RL12: Reading controller acknowledges all but last
// RL13: Last read byte left unacknowledged
// RL14: After no-ack, release data line
// RL15: Write byte goes to control register
// RL16: Read returns device data
// RL17: Address last bit: one read, zero write
// RL18: Keep only last written byte
// RL19: Low four bits enable channels zero-three
// RL20: New selection applies after STOP
// RL21: Ack only matching prefix and select pins
// RL22: Read returns current control register
// RL23: Reset mid-transfer aborts, releases data
module i2sw_target
    import i2sw_pkg::*;
(
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     por_n_i,
    // Address select pins
    input  wire logic                     addr_select_pin_0_i,
    input  wire logic                     addr_select_pin_1_i,
    input  wire logic                     addr_select_pin_2_i,
    // Link
    i2sw_if.target                        bus,
    // Channel enables and control register
    output logic                          chan0_enable_o,
    output logic                          chan1_enable_o,
    output logic                          chan2_enable_o,
    output logic                          chan3_enable_o,
    output logic [I2SW_BYTE_BITS-1:0]     ctrl_o
);
    typedef enum logic [2:0] {
        I2SW_T_IDLE, I2SW_T_ADDR, I2SW_T_AACK, I2SW_T_WDATA, I2SW_T_WACK,
        I2SW_T_RDATA, I2SW_T_RACK
    } i2sw_tst_e;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [2:0] sel_m;
        logic [2:0] sel_s;
        logic       scl_q;
        logic       sda_q;
        i2sw_tst_e  st;
        logic [2:0] bcnt;
        logic       got8;
        logic [7:0] shf;
        logic [7:0] pend;
        logic       pend_v;
        logic [7:0] ctrl;
        logic       sda_oe;
    } i2sw_t_s;

    i2sw_t_s r;
    i2sw_t_s next_r;
    logic    rst_n;
    logic    scl_rise;
    logic    scl_fall;
    logic    start_c;
    logic    stop_c;

    // Either reset source resets all state
    assign rst_n    = reset_n_i & por_n_i; // [RL1] [RL2] [RL23]
    // Edges read only the second synchroniser stage
    assign scl_rise = r.scl_s[1] & ~r.scl_q;
    assign scl_fall = ~r.scl_s[1] & r.scl_q;
    assign start_c  = r.scl_s[1] & r.scl_q & r.sda_q & ~r.sda_s[1]; // [RL4] [RL6]
    assign stop_c   = r.scl_s[1] & r.scl_q & ~r.sda_q & r.sda_s[1]; // [RL4] [RL7]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r       = r;
        next_r.scl_s = {r.scl_s[0], bus.scl};
        next_r.sda_s = {r.sda_s[0], bus.sda};
        // Address pins are board levels from outside the clock: two stages
        next_r.sel_m = {addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i};
        next_r.sel_s = r.sel_m;
        next_r.scl_q = r.scl_s[1];
        next_r.sda_q = r.sda_s[1];
        if (start_c) begin
            next_r.st     = I2SW_T_ADDR; // [RL6]
            next_r.bcnt   = 3'h0;
            next_r.got8   = 1'b0;
            next_r.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_r.st     = I2SW_T_IDLE; // [RL7]
            next_r.sda_oe = 1'b0;
            if (r.pend_v) begin
                next_r.ctrl   = r.pend; // [RL20]
                next_r.pend_v = 1'b0;
            end
        end else begin
            case (r.st)
                I2SW_T_IDLE: begin
                    next_r.sda_oe = 1'b0;
                end
                I2SW_T_ADDR, I2SW_T_WDATA: begin
                    if (scl_rise) begin
                        next_r.shf  = {r.shf[6:0], r.sda_s[1]}; // [RL3]
                        next_r.bcnt = r.bcnt + 3'h1;
                        // Flag the eighth bit; a wrapped count alone would also
                        // match the first clock fall right after START
                        next_r.got8 = (r.bcnt == I2SW_BIT_LAST); // [RL8]
                    end
                end
                I2SW_T_AACK, I2SW_T_WACK: begin
                    if (scl_fall) begin
                        next_r.sda_oe = 1'b0;
                        if (r.st == I2SW_T_AACK && r.shf[0] == I2SW_DIR_READ) begin // [RL17]
                            next_r.st     = I2SW_T_RDATA;
                            next_r.shf    = r.ctrl; // [RL16] [RL22]
                            next_r.sda_oe = ~r.ctrl[7];
                        end else begin
                            next_r.st = I2SW_T_WDATA;
                        end
                        next_r.bcnt = 3'h0;
                    end
                end
                I2SW_T_RDATA: begin
                    if (scl_fall) begin
                        if (r.bcnt == I2SW_BIT_LAST) begin
                            next_r.sda_oe = 1'b0; // [RL9]
                            next_r.st     = I2SW_T_RACK;
                        end else begin
                            next_r.shf    = {r.shf[6:0], 1'b0};
                            next_r.sda_oe = ~r.shf[6];
                        end
                        next_r.bcnt = r.bcnt + 3'h1;
                    end
                end
                I2SW_T_RACK: begin
                    if (scl_rise) begin
                        // Controller ack low means another byte
                        if (r.sda_s[1]) begin
                            next_r.st = I2SW_T_IDLE; // [RL13] [RL14]
                        end
                    end else if (scl_fall) begin
                        next_r.st     = I2SW_T_RDATA; // [RL12]
                        next_r.shf    = r.ctrl;
                        next_r.sda_oe = ~r.ctrl[7];
                        next_r.bcnt   = 3'h0;
                    end
                end
                default: begin
                    next_r.st = I2SW_T_IDLE;
                end
            endcase
            // End of the eighth receive bit: decide on the ack slot
            if ((r.st == I2SW_T_ADDR || r.st == I2SW_T_WDATA) && scl_fall
                && r.got8) begin
                next_r.got8 = 1'b0;
                if (r.st == I2SW_T_ADDR) begin
                    if (r.shf[7:4] == I2SW_PREFIX && r.shf[3:1] == r.sel_s) begin // [RL21]
                        next_r.st     = I2SW_T_AACK;
                        next_r.sda_oe = 1'b1; // [RL10] [RL11]
                    end else begin
                        next_r.st = I2SW_T_IDLE;
                    end
                end else begin
                    next_r.st     = I2SW_T_WACK;
                    next_r.sda_oe = 1'b1; // [RL8] [RL10] [RL11]
                    next_r.pend   = r.shf; // [RL15] [RL18]
                    next_r.pend_v = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r        <= '0; // [RL1] [RL2] [RL23]
            r.scl_s  <= 2'b11;
            r.sda_s  <= 2'b11;
            r.scl_q  <= 1'b1;
            r.sda_q  <= 1'b1;
            r.ctrl   <= I2SW_CTRL_RST;
            r.st     <= I2SW_T_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Channel enables from the live register
    assign chan0_enable_o = r.ctrl[0]; // [RL19]
    assign chan1_enable_o = r.ctrl[1];
    assign chan2_enable_o = r.ctrl[2];
    assign chan3_enable_o = r.ctrl[3];
    assign ctrl_o         = r.ctrl;
    assign bus.sda_s_oe   = r.sda_oe;
endmodule : i2sw_target

// ===== logic/i2sw_ctrl.sv
`timescale 1ns/10ps
module i2sw_ctrl
    import i2sw_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_n_i,
    // Command
    input  wire logic                  go_i,
    input  wire logic [6:0]            addr_i,
    input  wire logic                  rd_i,
    input  wire logic [7:0]            wdata_i,
    input  wire logic [3:0]            nbytes_i,
    // Status
    output logic                       busy_o,
    output logic                       nack_o,
    output logic [7:0]                 rdata_o,
    output logic                       rvalid_o,
    // Link
    i2sw_if.ctrl                       bus
);
    typedef enum logic [2:0] {
        I2SW_C_IDLE, I2SW_C_START, I2SW_C_BIT, I2SW_C_STOP, I2SW_C_DONE
    } i2sw_cst_e;

    typedef struct packed {
        i2sw_cst_e  st;
        logic [7:0] div;
        logic [1:0] ph;
        logic [3:0] bit_n;
        logic [3:0] left;
        logic [7:0] shf;
        logic       rd;
        logic       addr_ph;
        logic [7:0] wd;
        logic       scl_oe;
        logic       sda_oe;
        logic       nack;
        logic [7:0] rdata;
        logic       rvalid;
        logic [1:0] sda_s;
    } i2sw_c_s;

    i2sw_c_s r;
    i2sw_c_s next_r;
    logic    tick;

    assign tick = (r.div == I2SW_HALF_LAST);

    // ------------------------------------------------------------
    // Controller sequencer; one quarter step per tick
    // ------------------------------------------------------------
    always_comb begin
        next_r        = r;
        next_r.rvalid = 1'b0;
        next_r.sda_s  = {r.sda_s[0], bus.sda};
        next_r.div    = tick ? 8'h00 : r.div + 8'h01;
        case (r.st)
            I2SW_C_IDLE: begin
                next_r.div = 8'h00;
                // Own clock known from its register; data line synchronised
                if (go_i && !r.scl_oe && r.sda_s[1]) begin // [RL5]
                    next_r.st      = I2SW_C_START;
                    next_r.shf     = {addr_i, rd_i}; // [RL17]
                    next_r.rd      = rd_i;
                    next_r.wd      = wdata_i;
                    next_r.left    = (nbytes_i == I2SW_CNT_ZERO) ? 4'h1 : nbytes_i;
                    next_r.addr_ph = 1'b1;
                    next_r.nack    = 1'b0;
                    next_r.ph      = 2'h0;
                end
            end
            I2SW_C_START: if (tick) begin
                next_r.sda_oe = 1'b1; // [RL6]
                next_r.ph     = r.ph + 2'h1;
                if (r.ph == 2'h1) begin
                    next_r.scl_oe = 1'b1;
                    next_r.st     = I2SW_C_BIT;
                    next_r.bit_n  = 4'h0;
                    next_r.ph     = 2'h0;
                end
            end
            I2SW_C_BIT: if (tick) begin
                next_r.ph = r.ph + 2'h1;
                case (r.ph)
                    2'h0: begin
                        // Drive while clock low, so data holds through high
                        if (r.bit_n < 4'(I2SW_BYTE_BITS)) begin
                            next_r.sda_oe = (r.addr_ph || !r.rd) ? ~r.shf[7] : 1'b0; // [RL4]
                        end else begin
                            next_r.sda_oe = (!r.addr_ph && r.rd && r.left != 4'h1); // [RL12] [RL13]
                        end
                    end
                    2'h1: next_r.scl_oe = 1'b0;
                    2'h2: begin
                        if (r.bit_n < 4'(I2SW_BYTE_BITS)) begin
                            next_r.shf = {r.shf[6:0], r.sda_s[1]}; // [RL3]
                        end else if ((r.addr_ph || !r.rd) && r.sda_s[1]) begin
                            next_r.nack = 1'b1;
                        end
                    end
                    default: begin
                        next_r.scl_oe = 1'b1;
                        next_r.bit_n  = r.bit_n + 4'h1;
                        if (r.bit_n == 4'(I2SW_BYTE_BITS)) begin // [RL8] [RL9]
                            next_r.bit_n = 4'h0;
                            next_r.sda_oe = 1'b0;
                            if (!r.addr_ph && r.rd) begin
                                next_r.rdata  = r.shf;
                                next_r.rvalid = 1'b1;
                            end
                            if (r.nack || (!r.addr_ph && r.left == 4'h1)) begin
                                next_r.st = I2SW_C_STOP;
                            end else begin
                                if (!r.addr_ph) begin
                                    next_r.left = r.left - 4'h1;
                                end
                                next_r.addr_ph = 1'b0;
                                next_r.shf     = r.rd ? 8'hff : r.wd;
                            end
                            next_r.ph = 2'h0;
                        end
                    end
                endcase
            end
            I2SW_C_STOP: if (tick) begin
                next_r.ph = r.ph + 2'h1;
                case (r.ph)
                    2'h0: next_r.sda_oe = 1'b1;
                    2'h1: next_r.scl_oe = 1'b0;
                    default: begin
                        next_r.sda_oe = 1'b0; // [RL7]
                        next_r.st     = I2SW_C_DONE;
                    end
                endcase
            end
            I2SW_C_DONE: next_r.st = I2SW_C_IDLE;
            default: next_r.st = I2SW_C_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r       <= '0;
            r.st    <= I2SW_C_IDLE;
            r.sda_s <= 2'b11;
        end else begin
            r <= next_r;
        end
    end

    assign busy_o       = (r.st != I2SW_C_IDLE);
    assign nack_o       = r.nack;
    assign rdata_o      = r.rdata;
    assign rvalid_o     = r.rvalid;
    assign bus.scl_oe   = r.scl_oe;
    assign bus.sda_m_oe = r.sda_oe;
endmodule : i2sw_ctrl

// ===== dv/i2sw_monitor.sv
`timescale 1ns/10ps
module i2sw_monitor (
    // Clock and resets
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic por_n_i,
    // Link
    input  wire logic scl_oe,
    input  wire logic sda_m_oe,
    input  wire logic sda_s_oe,
    input  wire logic scl,
    input  wire logic sda
);
    wire        rst_n = reset_n_i & por_n_i;
    logic       addr_ph;
    logic [3:0] edges;

    default clocking cb @(posedge core_clk_i);
    endclocking

    // ------------------------------------------------------------
    // Helper: clock pulses counted from START to the first ack
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_ph <= 1'b0;
            edges   <= 4'h0;
        end else if (scl && $fell(sda)) begin
            addr_ph <= 1'b1;
            edges   <= 4'h0;
        end else begin
            if ($rose(scl) && edges != 4'hf) edges <= edges + 4'h1;
            if (sda_s_oe) addr_ph <= 1'b0;
        end
    end

    // Framing conditions on the resolved lines
    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $rose(sda);
    endsequence

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_slave_scl_low: assert property (disable iff (!rst_n)
        $changed(sda_s_oe) |-> !scl) else $error("target moved data while clock high");
    a_ack_hold: assert property (disable iff (!rst_n)
        $rose(scl) && sda_s_oe |-> sda_s_oe [*6]) else $error("ack not held through clock high");
    a_scl_high: assert property (disable iff (!rst_n)
        $rose(scl) |-> scl [*6]) else $error("clock pulse too short");
    a_start_quiet: assert property (disable iff (!rst_n)
        s_start |-> (!sda_s_oe) [*8]) else $error("target drove data right after start");
    a_stop_quiet: assert property (disable iff (!rst_n)
        s_stop |=> (!sda_s_oe) [*8]) else $error("target drove data after stop");
    a_idle_before: assert property (disable iff (!rst_n)
        s_start |-> $past(scl, 4) && $past(sda, 4)) else $error("start on busy bus");
    a_ack_count: assert property (disable iff (!rst_n)
        $rose(sda_s_oe) && addr_ph |-> edges == 4'h8) else $error("address ack misplaced");
    a_ctrl_data_move: assert property (disable iff (!rst_n)
        $changed(sda_m_oe) && scl |-> $fell(sda) || $rose(sda))
        else $error("controller moved data while clock high");
    a_start_clock: assert property (disable iff (!rst_n)
        s_start |-> ##[1:8] scl_oe) else $error("no clock pulse after start");
    // Reset itself is the condition here, so it cannot disable the check
    a_reset_quiet: assert property (
        !rst_n |-> !sda_s_oe) else $error("data line held in reset");
endmodule : i2sw_monitor

// ===== dv/i2sw_tb_top.sv
`timescale 1ns/10ps
module i2sw_tb_top
    import i2sw_pkg::*;
;
    typedef struct packed {
        logic [2:0] p;
        logic [6:0] a;
        logic       r;
        logic [7:0] d;
        logic [3:0] n;
        logic       nk;
        logic [7:0] c;
    } i2sw_row_s;

    logic       clk   = 1'b0;
    logic       rst_n = 1'b1; // Dropped at time zero so flops see an edge
    logic       pin_n = 1'b1;
    logic       por_n = 1'b1;
    logic       go    = 1'b0;
    logic       rd    = 1'b0;
    logic [2:0] pins  = 3'h5;
    logic [6:0] addr  = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [3:0] nb    = 4'h1;
    wire        busy;
    wire        nack;
    wire        rvalid;
    wire  [7:0] rdata;
    wire  [7:0] ctrl;
    wire  [3:0] chan;
    int         mismatches = 0;
    int         tests_run  = 0;
    int         rv_cnt     = 0;
    // Pins, address, read, data, count, expected nack, expected register
    i2sw_row_s  rows [6] = '{
        '{3'h5, {I2SW_PREFIX, 3'h5}, 1'h0, 8'ha5, 4'h1, 1'h0, 8'ha5},
        '{3'h5, {I2SW_PREFIX, 3'h5}, 1'h1, 8'h00, 4'h2, 1'h0, 8'ha5},
        '{3'h5, {I2SW_PREFIX, 3'h4}, 1'h0, 8'h3c, 4'h1, 1'h1, 8'ha5},
        '{3'h2, {~I2SW_PREFIX, 3'h2}, 1'h0, 8'h3c, 4'h1, 1'h1, 8'ha5},
        '{3'h2, {I2SW_PREFIX, 3'h2}, 1'h0, 8'h0f, 4'h3, 1'h0, 8'h0f},
        '{3'h2, {I2SW_PREFIX, 3'h2}, 1'h1, 8'h00, 4'h1, 1'h0, 8'h0f}};

    // ------------------------------------------------------------
    // Both ends joined over one link
    // ------------------------------------------------------------
    i2sw_if i_i2sw_if ();
    i2sw_target i_i2sw_target (.core_clk_i(clk), .reset_n_i(pin_n), .por_n_i(por_n),
        .addr_select_pin_0_i(pins[0]), .addr_select_pin_1_i(pins[1]),
        .addr_select_pin_2_i(pins[2]), .bus(i_i2sw_if.target),
        .chan0_enable_o(chan[0]), .chan1_enable_o(chan[1]), .chan2_enable_o(chan[2]),
        .chan3_enable_o(chan[3]), .ctrl_o(ctrl));
    i2sw_ctrl i_i2sw_ctrl (.core_clk_i(clk), .reset_n_i(rst_n), .go_i(go), .addr_i(addr),
        .rd_i(rd), .wdata_i(wdata), .nbytes_i(nb), .busy_o(busy), .nack_o(nack),
        .rdata_o(rdata), .rvalid_o(rvalid), .bus(i_i2sw_if.ctrl));
    i2sw_monitor i_i2sw_monitor (.core_clk_i(clk), .reset_n_i(pin_n), .por_n_i(por_n),
        .scl_oe(i_i2sw_if.scl_oe), .sda_m_oe(i_i2sw_if.sda_m_oe),
        .sda_s_oe(i_i2sw_if.sda_s_oe), .scl(i_i2sw_if.scl), .sda(i_i2sw_if.sda));

    // Clock, read byte counter, watchdog
    always #2 clk = ~clk;
    always @(posedge clk) if (rvalid === 1'b1) rv_cnt++;
    initial begin
        #200000;
        mismatches++;
        summarize();
    end

    task cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // One controller command, returns once busy drops
    task xfer(input logic [6:0] a, input logic r, input logic [7:0] d, input logic [3:0] n);
        @(posedge clk);
        addr  <= a;
        rd    <= r;
        wdata <= d;
        nb    <= n;
        go    <= 1'b1;
        rv_cnt = 0;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(negedge clk);
        while (busy !== 1'b0) @(negedge clk);
        // Target sees STOP through its synchronisers a few cycles later
        repeat (4) @(negedge clk);
    endtask : xfer

    task summarize();
        $display("Checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n <= 1'b0;
        pin_n <= 1'b0;
        por_n <= 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        cmp(ctrl, I2SW_CTRL_RST);
        cmp(8'(i_i2sw_if.sda_s_oe), 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        pin_n <= 1'b1;
        por_n <= 1'b1;
        // Table cases; pins settle through the synchronisers first
        foreach (rows[i]) begin
            @(posedge clk);
            pins <= rows[i].p;
            repeat (4) @(posedge clk);
            xfer(rows[i].a, rows[i].r, rows[i].d, rows[i].n);
            cmp(8'(nack), 8'(rows[i].nk));
            cmp(ctrl, rows[i].c);
            cmp(8'(chan), rows[i].c & 8'h0f);
            if (rows[i].r) begin
                cmp(rdata, rows[i].c);
                cmp(8'(rv_cnt), 8'(rows[i].n));
            end
        end
        // New selection stays pending past the data ack
        fork
            xfer({I2SW_PREFIX, 3'h2}, 1'b0, 8'h03, 4'h1);
            begin
                repeat (2) @(posedge i_i2sw_if.sda_s_oe);
                @(negedge i_i2sw_if.sda_s_oe);
                @(negedge clk);
                cmp(ctrl, 8'h0f);
            end
        join
        cmp(ctrl, 8'h03);
        // Reset pin pulsed while the target drives its ack
        fork
            xfer({I2SW_PREFIX, 3'h2}, 1'b0, 8'h0c, 4'h1);
            begin
                @(posedge i_i2sw_if.sda_s_oe);
                @(posedge clk);
                pin_n <= 1'b0;
                repeat (3) @(negedge clk);
                cmp(8'(i_i2sw_if.sda_s_oe), 8'h00);
                cmp(8'(chan), 8'h00);
                @(posedge clk);
                pin_n <= 1'b1;
            end
        join
        cmp(8'(nack), 8'h01);
        cmp(ctrl, 8'h00);
        // Power-on reset after a write, then read back the default
        xfer({I2SW_PREFIX, 3'h2}, 1'b0, 8'h09, 4'h1);
        cmp(ctrl, 8'h09);
        @(posedge clk);
        por_n <= 1'b0;
        repeat (3) @(negedge clk);
        cmp(ctrl, I2SW_CTRL_RST);
        @(posedge clk);
        por_n <= 1'b1;
        repeat (4) @(posedge clk);
        xfer({I2SW_PREFIX, 3'h2}, 1'b1, 8'h00, 4'h1);
        cmp(rdata, 8'h00);
        summarize();
    end
endmodule : i2sw_tb_top
